/* File: src/smbus_host.sv */
`timescale 1ns/10ps
module smbus_host
  import smbus_pkg::*;
(
  smbus_if.host SMB,
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BYTE = 2'b10,
    H_STOP = 2'b11
  } hstate_t;

  typedef enum logic [2:0] {
    ST_ADDRW = 3'b000,
    ST_CMD = 3'b001,
    ST_WCNT = 3'b010,
    ST_WDATA = 3'b011,
    ST_ADDRR = 3'b100,
    ST_RCNT = 3'b101,
    ST_RDATA = 3'b110
  } step_t;

  typedef struct packed {
    hstate_t st;
    step_t step;
    logic [1:0] qtr;
    logic [15:0] div;
    logic [3:0] bitn;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [1:0] idx;
    op_t op;
    logic plain;
    logic [7:0] cmd;
    logic [2:0] len;
    logic [HOST_BUF_BYTES-1:0][7:0] txbuf;
    logic [HOST_BUF_BYTES-1:0][7:0] rxbuf;
    logic [7:0] rcount;
    logic busy;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic sda_m;
    logic sda_s;
    logic pready;
    logic [31:0] prdata;
  } host_t;

  host_t q_r;
  host_t q_nxt;
  logic tick;
  logic last;
  logic [2:0] len_f;

  assign tick = q_r.div == 16'(QUARTER_CYC - 1);
  // the final read byte is the one left unacknowledged
  assign last = q_r.op == OP_BYTE_RD || {1'b0, q_r.idx} == q_r.len - 3'h1;
  assign len_f = PWDATA[XFER_LEN_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    q_nxt = q_r;
    q_nxt.sda_m = SMB.sda;
    q_nxt.sda_s = q_r.sda_m;
    q_nxt.div = tick ? 16'h0000 : q_r.div + 16'h0001;
    q_nxt.pready = PSEL & ~PENABLE;
    if (PSEL && !PENABLE) begin
      case (PADDR)
        HOST_CTRL: q_nxt.prdata = {28'h0000000, q_r.plain, q_r.op, 1'b0};
        HOST_XFER: q_nxt.prdata = {21'h000000, q_r.len, q_r.cmd};
        HOST_STATUS: q_nxt.prdata = {30'h00000000, q_r.nack, q_r.busy};
        HOST_DATA: q_nxt.prdata = q_r.rxbuf;
        HOST_RCOUNT: q_nxt.prdata = {24'h000000, q_r.rcount};
        default: q_nxt.prdata = 32'h00000000;
      endcase
    end
    // setup is refused while a transfer runs
    if (PSEL && PENABLE && q_r.pready && PWRITE && !q_r.busy) begin
      case (PADDR)
        HOST_CTRL: begin
          if (PWDATA[CTRL_GO_BIT]) begin
            q_nxt.busy = 1'b1;
            q_nxt.nack = 1'b0;
            q_nxt.op = op_t'(PWDATA[CTRL_OP_LSB +: 2]);
            q_nxt.plain = PWDATA[CTRL_PLAIN_BIT];
            q_nxt.st = H_START;
            q_nxt.step = ST_ADDRW;
            q_nxt.qtr = 2'b00;
            q_nxt.div = 16'h0000;
          end
        end
        HOST_XFER: begin
          q_nxt.cmd = PWDATA[7:0];
          q_nxt.len = (len_f == 3'h0 || len_f > 3'(HOST_BUF_BYTES)) ? 3'h1 : len_f;
        end
        HOST_DATA: q_nxt.txbuf = PWDATA;
        default: begin
        end
      endcase
    end
    if (tick && q_r.st != H_IDLE) begin
      q_nxt.qtr = q_r.qtr + 2'b01;
      case (q_r.st)
        H_START: begin
          case (q_r.qtr)
            2'b00: q_nxt.sda_oe = 1'b0;
            2'b01: q_nxt.scl_oe = 1'b0;
            2'b10: q_nxt.sda_oe = 1'b1;
            default: begin
              q_nxt.scl_oe = 1'b1;
              q_nxt.st = H_BYTE;
              q_nxt.bitn = 4'h0;
              q_nxt.tx = {SLAVE_ADDR, q_r.step == ST_ADDRR, 1'b1};
            end
          endcase
        end
        H_BYTE: begin
          case (q_r.qtr)
            2'b00: q_nxt.sda_oe = ~q_r.tx[8];
            2'b01: q_nxt.scl_oe = 1'b0;
            2'b10: q_nxt.rx = {q_r.rx[7:0], q_r.sda_s};
            default: begin
              q_nxt.scl_oe = 1'b1;
              q_nxt.tx = {q_r.tx[7:0], 1'b1};
              q_nxt.bitn = q_r.bitn + 4'h1;
              if (q_r.bitn == 4'h8) begin
                q_nxt.bitn = 4'h0;
                q_nxt.tx = {8'hff, 1'b0};
                if (q_r.step < ST_RCNT && q_r.rx[0]) begin
                  q_nxt.nack = 1'b1;
                  q_nxt.st = H_STOP;
                end else begin
                  case (q_r.step)
                    ST_ADDRW: begin
                      q_nxt.step = ST_CMD;
                      q_nxt.tx = {q_r.cmd, 1'b1};
                    end
                    ST_CMD: begin
                      if (q_r.op == OP_BYTE_RD || q_r.op == OP_BLK_RD) begin
                        q_nxt.st = H_START;
                        q_nxt.step = ST_ADDRR;
                      end else if (q_r.op == OP_BLK_WR && !q_r.plain) begin
                        q_nxt.step = ST_WCNT;
                        q_nxt.tx = {5'h00, q_r.len, 1'b1};
                      end else begin
                        q_nxt.step = ST_WDATA;
                        q_nxt.idx = 2'b00;
                        q_nxt.tx = {q_r.txbuf[0], 1'b1};
                      end
                    end
                    ST_WCNT: begin
                      q_nxt.step = ST_WDATA;
                      q_nxt.idx = 2'b00;
                      q_nxt.tx = {q_r.txbuf[0], 1'b1};
                    end
                    ST_WDATA: begin
                      q_nxt.idx = q_r.idx + 2'b01;
                      q_nxt.tx = {q_r.txbuf[q_r.idx + 2'b01], 1'b1};
                      if (q_r.op == OP_BYTE_WR || {1'b0, q_r.idx} == q_r.len - 3'h1) begin
                        q_nxt.st = H_STOP;
                      end
                    end
                    ST_ADDRR: begin
                      q_nxt.idx = 2'b00;
                      if (q_r.op == OP_BLK_RD) begin
                        q_nxt.step = ST_RCNT;
                      end else begin
                        q_nxt.step = ST_RDATA;
                        q_nxt.tx = {8'hff, 1'b1};
                      end
                    end
                    ST_RCNT: begin
                      q_nxt.rcount = q_r.rx[8:1];
                      q_nxt.step = ST_RDATA;
                      q_nxt.tx = {8'hff, last};
                    end
                    default: begin
                      q_nxt.rxbuf[q_r.idx] = q_r.rx[8:1];
                      q_nxt.idx = q_r.idx + 2'b01;
                      q_nxt.tx = {8'hff, q_r.op == OP_BYTE_RD || {1'b0, q_r.idx} == q_r.len - 3'h2};
                      if (last) begin
                        q_nxt.st = H_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        default: begin
          case (q_r.qtr)
            2'b00: q_nxt.sda_oe = 1'b1;
            2'b01: q_nxt.scl_oe = 1'b0;
            2'b10: q_nxt.sda_oe = 1'b0;
            default: begin
              q_nxt.st = H_IDLE;
              q_nxt.busy = 1'b0;
            end
          endcase
        end
      endcase
    end
    if (SRST) begin
      q_nxt = '0;
      q_nxt.sda_m = 1'b1;
      q_nxt.sda_s = 1'b1;
      q_nxt.len = 3'h1;
    end
  end

  always_ff @(posedge CLK) begin
    q_r <= q_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign SMB.scl_host_o = 1'b0;
  assign SMB.scl_host_oe = q_r.scl_oe;
  assign SMB.sda_host_o = 1'b0;
  assign SMB.sda_host_oe = q_r.sda_oe;
  assign PRDATA = q_r.prdata;
  assign PREADY = q_r.pready;
  assign PSLVERR = 1'b0;

endmodule : smbus_host

/* File: src/smbus_pkg.sv */
package smbus_pkg;
  // link framing
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  localparam int CMD_MODE_BIT = 7;
  localparam int NUM_CTRL = 4;
  // control byte offsets
  localparam logic [1:0] REG_DIFF_PAIR_ENABLE_A = 2'h0;
  localparam logic [1:0] REG_OUTPUT_ENABLE_AND_SPREAD = 2'h1;
  localparam logic [1:0] REG_BUS_CLOCK_ENABLE = 2'h2;
  localparam logic [1:0] REG_STOPPABLE_PAIR_SELECT = 2'h3;
  // power-up values
  localparam logic [7:0] RST_DIFF_PAIR_ENABLE_A = 8'hff;
  localparam logic [7:0] RST_OUTPUT_ENABLE_AND_SPREAD = 8'hf6;
  localparam logic [7:0] RST_BUS_CLOCK_ENABLE = 8'hff;
  localparam logic [7:0] RST_STOPPABLE_PAIR_SELECT = 8'h00;
  localparam int SPREAD_BIT = 0;
  // controller registers on APB
  localparam logic [11:0] HOST_CTRL = 12'h000;
  localparam logic [11:0] HOST_XFER = 12'h004;
  localparam logic [11:0] HOST_STATUS = 12'h008;
  localparam logic [11:0] HOST_DATA = 12'h00c;
  localparam logic [11:0] HOST_RCOUNT = 12'h010;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_PLAIN_BIT = 3;
  localparam int XFER_LEN_LSB = 8;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_NACK_BIT = 1;
  localparam int HOST_BUF_BYTES = 4;
  typedef enum logic [1:0] {
    OP_BYTE_WR = 2'b00,
    OP_BYTE_RD = 2'b01,
    OP_BLK_WR = 2'b10,
    OP_BLK_RD = 2'b11
  } op_t;
  // serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  // fast link keeps a full run of frames short; the quarter must stay well above the sync depth
  localparam int SCL_PERIOD_NS = 1000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage : smbus_pkg

/* File: src/smbus_if.sv */
`timescale 1ns/10ps
interface smbus_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // open drain with pull-up: low while any enabled driver drives low
  assign scl = ~((scl_host_oe & ~scl_host_o) | (scl_dev_oe & ~scl_dev_o));
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
  modport host(output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe, input scl, sda);
  modport dev(output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, input scl, sda);
endinterface : smbus_if

/* File: src/smbus_dev.sv */
`timescale 1ns/10ps
module smbus_dev
  import smbus_pkg::*;
(
  smbus_if.dev SMB,
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PLAIN_TWO_WIRE,
  input wire logic SOFT_BUS_CLOCK_STOP,
  input wire logic OUT_CLK_LOW,
  output logic [7:0] DIFF_PAIR_ENABLE_A,
  output logic [7:0] OUTPUT_ENABLE_AND_SPREAD,
  output logic [7:0] BUS_CLOCK_ENABLE,
  output logic [7:0] STOPPABLE_PAIR_SELECT,
  output logic SPREAD_ON,
  output logic [7:2] STOPPED_PAIRS
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX = 3'b001,
    D_RXACK = 3'b010,
    D_TX = 3'b011,
    D_TXACK = 3'b100,
    D_SKIP = 3'b101
  } dstate_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD = 2'b01,
    PH_CNT = 2'b10,
    PH_DATA = 2'b11
  } phase_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    dstate_t st;
    phase_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [6:0] ptr;
    logic rd;
    logic cnt_sent;
    logic sda_oe;
    logic [NUM_CTRL-1:0][7:0] ctrl;
    logic [7:2] stopped;
  } dev_t;

  dev_t q_r;
  dev_t q_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  ////////////////////////////////////////////////////////////////////////////
  // offsets past the last control byte read as zero
  function automatic logic [7:0] rd_byte(input dev_t s);
    if (s.ptr < 7'(NUM_CTRL)) begin
      rd_byte = s.ctrl[s.ptr[1:0]];
    end else begin
      rd_byte = 8'h00;
    end
  endfunction : rd_byte

  // fetch the next byte to shift out and drive its msb
  function automatic dev_t load_tx(input dev_t s);
    dev_t t;
    logic [7:0] b;
    t = s;
    if (!s.cmd[CMD_MODE_BIT] && !s.cnt_sent) begin
      b = 8'(NUM_CTRL);
      t.cnt_sent = 1'b1;
    end else begin
      b = rd_byte(s);
      t.ptr = s.ptr + 7'h01;
    end
    t.sh = b;
    t.sda_oe = ~b[7];
    t.cnt = 4'h0;
    t.st = D_TX;
    return t;
  endfunction : load_tx

  ////////////////////////////////////////////////////////////////////////////
  // edges are taken only from the second synchroniser stage onward
  assign scl_rise = q_r.scl_s & ~q_r.scl_d;
  assign scl_fall = ~q_r.scl_s & q_r.scl_d;
  assign start_seen = q_r.scl_s & q_r.scl_d & q_r.sda_d & ~q_r.sda_s;
  assign stop_seen = q_r.scl_s & q_r.scl_d & ~q_r.sda_d & q_r.sda_s;

  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_m = SMB.scl;
    q_nxt.scl_s = q_r.scl_m;
    q_nxt.scl_d = q_r.scl_s;
    q_nxt.sda_m = SMB.sda;
    q_nxt.sda_s = q_r.sda_m;
    q_nxt.sda_d = q_r.sda_s;
    case (q_r.st)
      D_IDLE, D_SKIP: begin
        q_nxt.sda_oe = 1'b0;
      end
      D_RX: begin
        if (scl_rise) begin
          q_nxt.sh = {q_r.sh[6:0], q_r.sda_s};
          q_nxt.cnt = q_r.cnt + 4'h1;
        end else if (scl_fall && q_r.cnt == 4'h8) begin
          q_nxt.cnt = 4'h0;
          q_nxt.sda_oe = 1'b1;
          q_nxt.st = D_RXACK;
          case (q_r.ph)
            PH_ADDR: begin
              if (q_r.sh[7:1] == SLAVE_ADDR) begin
                q_nxt.rd = q_r.sh[0];
              end else begin
                q_nxt.sda_oe = 1'b0;
                q_nxt.st = D_SKIP;
              end
            end
            PH_CMD: begin
              q_nxt.cmd = q_r.sh;
              // block access always starts at the lowest byte
              q_nxt.ptr = q_r.sh[CMD_MODE_BIT] ? q_r.sh[6:0] : 7'h00;
            end
            PH_DATA: begin
              if (q_r.ptr < 7'(NUM_CTRL)) begin
                q_nxt.ctrl[q_r.ptr[1:0]] = q_r.sh;
              end
              q_nxt.ptr = q_r.ptr + 7'h01;
            end
            default: begin
              // byte count is acknowledged and discarded
            end
          endcase
        end
      end
      D_RXACK: begin
        if (scl_fall) begin
          q_nxt.sda_oe = 1'b0;
          if (q_r.rd) begin
            q_nxt = load_tx(q_nxt);
          end else begin
            q_nxt.st = D_RX;
            case (q_r.ph)
              PH_ADDR: q_nxt.ph = PH_CMD;
              PH_CMD: begin
                if (q_r.cmd[CMD_MODE_BIT] || PLAIN_TWO_WIRE) begin
                  q_nxt.ph = PH_DATA;
                end else begin
                  q_nxt.ph = PH_CNT;
                end
              end
              default: q_nxt.ph = PH_DATA;
            endcase
          end
        end
      end
      D_TX: begin
        if (scl_fall) begin
          if (q_r.cnt == 4'h7) begin
            q_nxt.sda_oe = 1'b0;
            q_nxt.st = D_TXACK;
          end else begin
            q_nxt.sh = {q_r.sh[6:0], 1'b0};
            q_nxt.sda_oe = ~q_r.sh[6];
            q_nxt.cnt = q_r.cnt + 4'h1;
          end
        end
      end
      D_TXACK: begin
        if (scl_rise && q_r.sda_s) begin
          q_nxt.st = D_SKIP;
        end else if (scl_fall) begin
          q_nxt = load_tx(q_nxt);
        end
      end
      default: begin
        q_nxt.st = D_IDLE;
        q_nxt.sda_oe = 1'b0;
      end
    endcase
    // start and stop override any bit phase, also mid-byte
    if (start_seen) begin
      q_nxt.st = D_RX;
      q_nxt.ph = PH_ADDR;
      q_nxt.cnt = 4'h0;
      q_nxt.rd = 1'b0;
      q_nxt.cnt_sent = 1'b0;
      q_nxt.sda_oe = 1'b0;
    end else if (stop_seen) begin
      q_nxt.st = D_IDLE;
      q_nxt.sda_oe = 1'b0;
    end
    // stop state only moves while the outputs sit low: no runt pulses
    if (OUT_CLK_LOW) begin
      q_nxt.stopped = SOFT_BUS_CLOCK_STOP ? q_r.ctrl[REG_STOPPABLE_PAIR_SELECT][7:2] : 6'h00;
    end
    if (SRST) begin
      q_nxt = '0;
      q_nxt.scl_m = 1'b1;
      q_nxt.scl_s = 1'b1;
      q_nxt.scl_d = 1'b1;
      q_nxt.sda_m = 1'b1;
      q_nxt.sda_s = 1'b1;
      q_nxt.sda_d = 1'b1;
      q_nxt.ctrl[REG_DIFF_PAIR_ENABLE_A] = RST_DIFF_PAIR_ENABLE_A;
      q_nxt.ctrl[REG_OUTPUT_ENABLE_AND_SPREAD] = RST_OUTPUT_ENABLE_AND_SPREAD;
      q_nxt.ctrl[REG_BUS_CLOCK_ENABLE] = RST_BUS_CLOCK_ENABLE;
      q_nxt.ctrl[REG_STOPPABLE_PAIR_SELECT] = RST_STOPPABLE_PAIR_SELECT;
    end
  end

  always_ff @(posedge CLK) begin
    q_r <= q_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // the slave never stretches the serial clock
  assign SMB.scl_dev_o = 1'b0;
  assign SMB.scl_dev_oe = 1'b0;
  assign SMB.sda_dev_o = 1'b0;
  assign SMB.sda_dev_oe = q_r.sda_oe;
  assign DIFF_PAIR_ENABLE_A = q_r.ctrl[REG_DIFF_PAIR_ENABLE_A];
  assign OUTPUT_ENABLE_AND_SPREAD = q_r.ctrl[REG_OUTPUT_ENABLE_AND_SPREAD];
  assign BUS_CLOCK_ENABLE = q_r.ctrl[REG_BUS_CLOCK_ENABLE];
  assign STOPPABLE_PAIR_SELECT = q_r.ctrl[REG_STOPPABLE_PAIR_SELECT];
  assign SPREAD_ON = q_r.ctrl[REG_OUTPUT_ENABLE_AND_SPREAD][SPREAD_BIT];
  assign STOPPED_PAIRS = q_r.stopped;

endmodule : smbus_dev

/* File: bench/smbus_checker.sv */
`timescale 1ns/10ps
module smbus_checker
  import smbus_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_oe,
  input wire logic sda_dev_oe,
  input wire logic OUT_CLK_LOW,
  input wire logic SOFT_BUS_CLOCK_STOP,
  input wire logic [7:0] OUTPUT_ENABLE_AND_SPREAD,
  input wire logic [7:0] STOPPABLE_PAIR_SELECT,
  input wire logic SPREAD_ON,
  input wire logic [7:2] STOPPED_PAIRS
);
  typedef struct packed {
    logic [3:0] cnt;
    logic in_frame;
    logic scl_d;
    logic sda_d;
  } mon_t;
  mon_t mon_r;
  mon_t mon_nxt;
  logic rise;
  logic [5:0] stop_want;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  assign rise = scl & ~mon_r.scl_d;
  assign stop_want = SOFT_BUS_CLOCK_STOP ? STOPPABLE_PAIR_SELECT[7:2] : 6'h00;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mon_nxt = mon_r;
    mon_nxt.scl_d = scl;
    mon_nxt.sda_d = sda;
    // start or restart restarts the bit count
    if (scl && mon_r.scl_d && mon_r.sda_d && !sda) begin
      mon_nxt.cnt = 4'h0;
      mon_nxt.in_frame = 1'b1;
    end else if (scl && mon_r.scl_d && !mon_r.sda_d && sda) begin
      mon_nxt.in_frame = 1'b0;
    end else if (rise && mon_r.cnt != 4'hf) begin
      mon_nxt.cnt = mon_r.cnt + 4'h1;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mon_r <= {4'hf, 3'b011};
    end else begin
      mon_r <= mon_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_addr_quiet: assert property (mon_r.in_frame && mon_r.cnt < 4'h8 |-> !sda_dev_oe)
    else $error("device drove sda during address bits");
  a_addr_ack: assert property (mon_r.in_frame && rise && mon_r.cnt == 4'h8 |-> !sda)
    else $error("own address not acknowledged");
  a_dev_edge_low: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device changed sda while scl high");
  a_scl_high_hold: assert property (rise |-> scl [*8])
    else $error("scl high phase too short");
  a_idle_scl_free: assert property (!mon_r.in_frame |-> !scl_host_oe)
    else $error("scl pulled low outside a frame");
  a_stop_hold: assert property (!OUT_CLK_LOW |=> $stable(STOPPED_PAIRS))
    else $error("stop state changed while clocks not low");
  a_stop_value: assert property (OUT_CLK_LOW |=> STOPPED_PAIRS == $past(stop_want))
    else $error("stopped pairs differ from selection");
  a_spread_level: assert property ($changed(SPREAD_ON) |->
    !scl && SPREAD_ON == OUTPUT_ENABLE_AND_SPREAD[SPREAD_BIT])
    else $error("spread output differs from control bit");
  cover property (mon_r.in_frame && rise && mon_r.cnt == 4'h8);
  cover property (OUT_CLK_LOW && SOFT_BUS_CLOCK_STOP && (|STOPPABLE_PAIR_SELECT[7:2]));
  cover property (sda_dev_oe && mon_r.cnt == 4'hf);
endmodule : smbus_checker

/* File: bench/clock_gen_smbus_control_test.sv */
`timescale 1ns/10ps
module clock_gen_smbus_control_test;
  import smbus_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic plain, soft_stop, out_low, spread_on;
  logic [7:0] byte0, byte1, byte2, byte3;
  logic [7:2] stopped_pairs;
  int seed, n_errors, cmp_count;
  int mdl[4];
  smbus_if bus_if();
  smbus_dev smbus_dev_inst(.SMB(bus_if), .CLK(clk), .SRST(srst), .PLAIN_TWO_WIRE(plain),
    .SOFT_BUS_CLOCK_STOP(soft_stop), .OUT_CLK_LOW(out_low), .DIFF_PAIR_ENABLE_A(byte0),
    .OUTPUT_ENABLE_AND_SPREAD(byte1), .BUS_CLOCK_ENABLE(byte2), .STOPPABLE_PAIR_SELECT(byte3),
    .SPREAD_ON(spread_on), .STOPPED_PAIRS(stopped_pairs));
  smbus_host smbus_host_inst(.SMB(bus_if), .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  smbus_checker smbus_checker_inst(.CLK(clk), .SRST(srst), .scl(bus_if.scl), .sda(bus_if.sda),
    .scl_host_oe(bus_if.scl_host_oe), .sda_dev_oe(bus_if.sda_dev_oe), .OUT_CLK_LOW(out_low),
    .SOFT_BUS_CLOCK_STOP(soft_stop), .OUTPUT_ENABLE_AND_SPREAD(byte1), .STOPPABLE_PAIR_SELECT(byte3),
    .SPREAD_ON(spread_on), .STOPPED_PAIRS(stopped_pairs));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // low-phase marks arrive at random, so stop changes are tried at odd moments
  always @(posedge clk) begin
    out_low <= ($random(seed) & 32'h1) != 32'h0;
  end
  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // reserved bits go out with their power-up values
  function automatic logic [31:0] keep_rsv(input logic [31:0] v);
    return (v | 32'h0000_0001) & 32'hfeff_f7ff;
  endfunction : keep_rsv
  task automatic xfer(input op_t op, input logic [7:0] cmd, input logic [2:0] len, input logic pl,
    input logic [31:0] wd);
    logic [31:0] rd;
    int n;
    plain <= pl;
    apb(1'b1, HOST_DATA, wd, rd);
    apb(1'b1, HOST_XFER, {21'h0, len, cmd}, rd);
    apb(1'b1, HOST_CTRL, {28'h0, pl, op, 1'b1}, rd);
    n = 0;
    do begin
      apb(1'b0, HOST_STATUS, 32'h0, rd);
      n++;
    end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 20000);
    check("busy", {31'h0, rd[STATUS_BUSY_BIT]}, 32'h0);
    check("nack", {31'h0, rd[STATUS_NACK_BIT]}, 32'h0);
  endtask : xfer
  task automatic check_regs();
    check("byte0", {24'h0, byte0}, mdl[0]);
    check("byte1", {24'h0, byte1}, mdl[1]);
    check("byte2", {24'h0, byte2}, mdl[2]);
    check("byte3", {24'h0, byte3}, mdl[3]);
    check("spread", {31'h0, spread_on}, mdl[1] & 1);
  endtask : check_regs
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // each serial bit costs a hundred clocks; all frames fit well inside this span
    #600_000;
    n_errors++;
    print_verdict();
  end
  initial begin
    seed = 41613;
    n_errors = 0;
    cmp_count = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    plain = 1'b0;
    soft_stop = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    mdl = '{32'hff, 32'hf6, 32'hff, 32'h00};
    check_regs();
    apb(1'b0, 12'h0fc, 32'h0, q);
    check("unmapped", q, 32'h0);
    d = keep_rsv($random(seed));
    for (int i = 0; i < 4; i++) begin
      mdl[i] = int'(d[8*i +: 8]);
    end
    xfer(OP_BLK_WR, 8'h00, 3'd4, 1'b0, d);
    check_regs();
    d = keep_rsv($random(seed));
    mdl[0] = int'(d[7:0]);
    mdl[1] = int'(d[15:8]);
    xfer(OP_BLK_WR, 8'h00, 3'd2, 1'b1, d);
    check_regs();
    d = ($random(seed) & 32'hfe) | 32'h80;
    mdl[3] = int'(d[7:0]);
    xfer(OP_BYTE_WR, 8'h83, 3'd1, 1'b0, d);
    check_regs();
    xfer(OP_BYTE_RD, 8'h81, 3'd1, 1'b0, 32'h0);
    apb(1'b0, HOST_DATA, 32'h0, q);
    check("byte read", {24'h0, q[7:0]}, mdl[1]);
    xfer(OP_BLK_RD, 8'h00, 3'd4, 1'b0, 32'h0);
    apb(1'b0, HOST_RCOUNT, 32'h0, q);
    check("count", q, 32'h4);
    apb(1'b0, HOST_DATA, 32'h0, q);
    check("block read", q, {mdl[3][7:0], mdl[2][7:0], mdl[1][7:0], mdl[0][7:0]});
    soft_stop <= 1'b1;
    repeat (16) @(posedge clk);
    check("stopped", {26'h0, stopped_pairs}, (mdl[3] >> 2) & 63);
    soft_stop <= 1'b0;
    repeat (16) @(posedge clk);
    check("resumed", {26'h0, stopped_pairs}, 32'h0);
    print_verdict();
  end
endmodule : clock_gen_smbus_control_test
